// ---- rtl/dac_word_pkg.sv ----
/*
  Shared constants and carriers for the serial word decoder.
  Assumes a 24-bit frame, MSB first, with a 14-bit data field.
*/
package dac_word_pkg;
  // ----------------------------------------
  // Frame layout
  // ----------------------------------------
  localparam int FRAME_BITS = 24;
  localparam int DATA_FIELD_W = 14;
  localparam int ADDR_W = 4;
  localparam int CNT_W = 5;
  localparam int BANK_POS = 23;
  localparam int RW_POS = 22;
  localparam int ADDR_POS = 16;
  localparam int SEL_POS = 14;

  // ----------------------------------------
  // Register selector codes
  // ----------------------------------------
  localparam logic [1:0] SEL_CODE = 2'h3;
  localparam logic [1:0] SEL_OFFSET = 2'h2;
  localparam logic [1:0] SEL_GAIN = 2'h1;
  localparam logic [1:0] SEL_SFR = 2'h0;

  // ----------------------------------------
  // Reset values per resolution
  // ----------------------------------------
  localparam logic [13:0] GAIN_RST_14 = 14'h3ffe;
  localparam logic [11:0] GAIN_RST_12 = 12'hffe;
  localparam logic [13:0] OFS_RST_14 = 14'h2000;
  localparam logic [11:0] OFS_RST_12 = 12'h800;
  localparam logic [13:0] CODE_RST = 14'h0000;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic bank;
    logic rw;
    logic [1:0] zero;
    logic [ADDR_W-1:0] channel_address;
    logic reg_select_hi;
    logic reg_select_lo;
    logic [DATA_FIELD_W-1:0] data_field;
  } frame_t;

  typedef struct packed {
    logic [ADDR_W-1:0] chan;
    logic bank;
    logic [DATA_FIELD_W-1:0] code;
  } dac_update_t;
endpackage : dac_word_pkg

// ---- rtl/dac_serial_word_decoder.sv ----
/*
  Serial word decoder: link shift logic on link_sclk, register
  file, readback and gain/offset correction on mclk.
  Assumes the host honours sync_n setup before the first sclk edge.
*/
// Function
// - 14-bit variants use 14-bit data path
// - 12-bit variant uses 12-bit data path
// - Selector routes to code, offset, gain
// - Selector zero targets special function space
// - Store data into selected channel register
// - 14-bit input code is straight binary
// - 14-bit offset is offset binary
// - 14-bit gain keeps LSB zero
// - 12-bit code binary, offset offset binary
// - 12-bit gain keeps LSB zero
// - Interface pin high selects serial link
// - Link idles until frame sync falls
// - Chain pin selects daisy chain, data out
// - Words are 24 bits, MSB first
// - Fixed field layout of the word
// - 12-bit data sits in bits 13-2
// - 8-channel uses address bits 18-16
// - Bank bit picks A or B
// - Read bit requests readback, no write
// - Address field selects the channel
// - Readback shifts out during next frame
// - Short frames are discarded
// - Corrected code from gain and offset
// - Gain and offset reset defaults
`timescale 1ns/1ps
module dac_serial_word_decoder
  import dac_word_pkg::*;
#(
  parameter int RES = 14,
  parameter int CHANNELS = 16
) (
  // System
  input wire logic mclk,
  input wire logic nrst,
  // Serial link
  input wire logic link_sclk,
  input wire logic sync_n,
  input wire logic din,
  output logic sdo,
  // Mode pins
  input wire logic iface_sel,
  input wire logic chain_enable_pin,
  input wire logic toggle_en,
  // Status and results
  output logic iface_awake,
  output logic bad_frame,
  output logic sfr_wr,
  output frame_t sfr_word,
  output logic dac_valid,
  output dac_update_t dac_update
);
  localparam int CH_W = $clog2(CHANNELS);
  localparam int PW = 2 * RES + 2;
  localparam int SW = RES + 3;
  localparam logic [RES-1:0] GAIN_RST =
    (RES == 12) ? RES'(GAIN_RST_12) : RES'(GAIN_RST_14);
  localparam logic [RES-1:0] OFS_RST =
    (RES == 12) ? RES'(OFS_RST_12) : RES'(OFS_RST_14);
  localparam logic [SW-1:0] HALF = SW'(OFS_RST);
  localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(FRAME_BITS);

  typedef enum logic [1:0] {ST_IDLE, ST_DECODE, ST_CALC} state_t;

  // ----------------------------------------
  // Frame start marker
  // ----------------------------------------
  // Toggles on sync_n fall so the counter restarts even when sclk
  // was stopped between frames.
  logic start_tgl_q;
  always_ff @(negedge sync_n or negedge nrst) begin
    if (!nrst) start_tgl_q <= 1'b0;
    else start_tgl_q <= ~start_tgl_q;
  end

  // ----------------------------------------
  // Link domain shifter
  // ----------------------------------------
  logic seen_tgl_q;
  logic [CNT_W-1:0] cnt_q;
  logic [FRAME_BITS-1:0] shreg_q;
  logic sdo_q;
  logic chain_mode_q;
  logic [FRAME_BITS-1:0] rb_word_q;
  wire new_frame = start_tgl_q ^ seen_tgl_q;
  wire cnt_full = (cnt_q == FULL_CNT);
  // Standalone ignores sclk after 24 bits; chain keeps rippling
  wire shift_more = !cnt_full || chain_mode_q;
  wire [FRAME_BITS-1:0] shift_in = {shreg_q[FRAME_BITS-2:0], din};
  wire [FRAME_BITS-1:0] load_in = {rb_word_q[FRAME_BITS-2:0], din};

  always_ff @(posedge link_sclk or negedge nrst) begin
    if (!nrst) begin
      seen_tgl_q <= 1'b0;
      cnt_q <= '0;
      shreg_q <= '0;
      sdo_q <= 1'b0;
    end else if (!sync_n) begin
      if (new_frame) begin
        seen_tgl_q <= start_tgl_q;
        cnt_q <= CNT_W'(1);
        shreg_q <= load_in;
        sdo_q <= rb_word_q[FRAME_BITS-1];
      end else if (shift_more) begin
        shreg_q <= shift_in;
        sdo_q <= shreg_q[FRAME_BITS-1];
        cnt_q <= cnt_full ? cnt_q : cnt_q + CNT_W'(1);
      end
    end
  end
  assign sdo = sdo_q;

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  localparam int NPIN = 4;
  wire [NPIN-1:0] pin_raw = {toggle_en, chain_enable_pin, iface_sel, sync_n};
  logic [NPIN-1:0] s1_q, s2_q, s3_q, stable_q;
  wire [NPIN-1:0] stable_d;
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_pin
      assign stable_d[gi] = (s2_q[gi] == s3_q[gi]) ? s2_q[gi] : stable_q[gi];
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          s1_q[gi] <= 1'b1;
          s2_q[gi] <= 1'b1;
          s3_q[gi] <= 1'b1;
          stable_q[gi] <= 1'b1;
        end else begin
          s1_q[gi] <= pin_raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          stable_q[gi] <= stable_d[gi];
        end
      end
    end
  endgenerate
  wire frame_rise = stable_d[0] & ~stable_q[0];
  wire serial_mode = stable_q[1];
  wire toggle_mode = stable_q[3];

  // ----------------------------------------
  // Decode fields
  // ----------------------------------------
  state_t state_q;
  frame_t word_q;
  logic [CNT_W-1:0] cnt_cap_q;
  wire [CH_W-1:0] chan = word_q.channel_address[CH_W-1:0];
  wire [1:0] sel = {word_q.reg_select_hi, word_q.reg_select_lo};
  // 12-bit data sits high in the field; low bits are dropped
  wire [RES-1:0] data = word_q.data_field[DATA_FIELD_W-1 -: RES];
  wire bank_b = word_q.bank & toggle_mode;
  wire short_frame = (cnt_cap_q != FULL_CNT);
  wire do_write = (state_q == ST_DECODE) && !short_frame && !word_q.rw;
  wire do_read = (state_q == ST_DECODE) && !short_frame && word_q.rw;
  wire we_code = do_write && (sel == SEL_CODE);
  wire we_ofs = do_write && (sel == SEL_OFFSET);
  wire we_gain = do_write && (sel == SEL_GAIN);
  wire we_sfr = do_write && (sel == SEL_SFR);

  // ----------------------------------------
  // Channel register file
  // ----------------------------------------
  logic [RES-1:0] code_a_q [CHANNELS];
  logic [RES-1:0] code_b_q [CHANNELS];
  logic [RES-1:0] ofs_q [CHANNELS];
  logic [RES-1:0] gain_q [CHANNELS];
  generate
    for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
      wire hit = (chan == CH_W'(gi));
      always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
          code_a_q[gi] <= RES'(CODE_RST);
          code_b_q[gi] <= RES'(CODE_RST);
          ofs_q[gi] <= OFS_RST;
          gain_q[gi] <= GAIN_RST;
        end else begin
          if (we_code && hit && !bank_b) code_a_q[gi] <= data;
          if (we_code && hit && bank_b) code_b_q[gi] <= data;
          if (we_ofs && hit) ofs_q[gi] <= data;
          if (we_gain && hit) gain_q[gi] <= {data[RES-1:1], 1'b0};
        end
      end
    end
  endgenerate

  // ----------------------------------------
  // Readback selection
  // ----------------------------------------
  wire [RES-1:0] code_sel = bank_b ? code_b_q[chan] : code_a_q[chan];
  wire [RES-1:0] rb_reg = (sel == SEL_CODE) ? code_sel :
                          (sel == SEL_OFFSET) ? ofs_q[chan] :
                          (sel == SEL_GAIN) ? gain_q[chan] : '0;
  wire [DATA_FIELD_W-1:0] rb_data =
    DATA_FIELD_W'(rb_reg) << (DATA_FIELD_W - RES);
  wire [FRAME_BITS-1:0] rb_next = {word_q[FRAME_BITS-1:SEL_POS], rb_data};

  // ----------------------------------------
  // Gain and offset correction
  // ----------------------------------------
  logic [CH_W-1:0] calc_ch_q;
  logic calc_bank_q;
  wire [RES-1:0] x1 = calc_bank_q ? code_b_q[calc_ch_q] : code_a_q[calc_ch_q];
  wire [RES:0] gain_p2 = {1'b0, gain_q[calc_ch_q]} + (RES+1)'(2);
  wire [PW-1:0] prod = PW'(gain_p2) * PW'(x1);
  wire [SW-1:0] corr = SW'(prod[2*RES:RES]) + SW'(ofs_q[calc_ch_q]) - HALF;
  wire corr_neg = corr[SW-1];
  wire corr_over = !corr_neg && (corr[SW-2:RES] != '0);
  wire [RES-1:0] corr_sat = corr_neg ? '0 :
                            corr_over ? {RES{1'b1}} : corr[RES-1:0];

  // ----------------------------------------
  // Control sequence
  // ----------------------------------------
  // Link word and count are static while sync_n is high, so the
  // synchronised rise qualifies them for capture here.
  wire take = frame_rise && serial_mode;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_IDLE;
      word_q <= '0;
      cnt_cap_q <= '0;
      rb_word_q <= '0;
      chain_mode_q <= 1'b0;
      calc_ch_q <= '0;
      calc_bank_q <= 1'b0;
    end else begin
      chain_mode_q <= stable_q[2];
      unique case (state_q)
        ST_IDLE: begin
          if (take) begin
            word_q <= frame_t'(shreg_q);
            cnt_cap_q <= cnt_q;
            state_q <= ST_DECODE;
          end
        end
        ST_DECODE: begin
          if (do_read) rb_word_q <= rb_next;
          else if (do_write) rb_word_q <= '0;
          calc_ch_q <= chan;
          calc_bank_q <= we_code & bank_b;
          state_q <= (we_code || we_ofs || we_gain) ? ST_CALC : ST_IDLE;
        end
        ST_CALC: state_q <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Output flops
  // ----------------------------------------
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      iface_awake <= 1'b0;
      bad_frame <= 1'b0;
      sfr_wr <= 1'b0;
      sfr_word <= '0;
      dac_valid <= 1'b0;
      dac_update <= '0;
    end else begin
      iface_awake <= !stable_q[0] || (state_q != ST_IDLE);
      bad_frame <= (state_q == ST_DECODE) && short_frame;
      sfr_wr <= we_sfr;
      if (we_sfr) sfr_word <= word_q;
      dac_valid <= (state_q == ST_CALC);
      if (state_q == ST_CALC) begin
        dac_update.chan <= ADDR_W'(calc_ch_q);
        dac_update.bank <= calc_bank_q;
        dac_update.code <= DATA_FIELD_W'(corr_sat);
      end
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);

  short_drop_a: assert property (
    (state_q == ST_DECODE) && short_frame |=> bad_frame && !sfr_wr ##1 !dac_valid)
    else $error("short frame not discarded");
  gain_store_a: assert property (
    we_gain |=> gain_q[$past(chan)] == {$past(data[RES-1:1]), 1'b0})
    else $error("gain not stored with zero lsb");
  code_store_a: assert property (
    we_code && !bank_b |=> code_a_q[$past(chan)] == $past(data))
    else $error("input code not stored");
  sfr_route_a: assert property (
    we_sfr |=> sfr_wr && sfr_word == $past(word_q) && state_q == ST_IDLE)
    else $error("special function write not routed");
  read_only_a: assert property (
    do_read |=> state_q == ST_IDLE && rb_word_q[23:14] == $past(word_q[23:14]))
    else $error("readback word wrong");
  take_frame_a: assert property (
    frame_rise && !serial_mode |=> state_q == ST_IDLE)
    else $error("frame taken in two-wire mode");
  calc_path_a: assert property (
    we_code || we_ofs || we_gain |=> state_q == ST_CALC ##1 dac_valid)
    else $error("correction not issued");
  sat_low_a: assert property (
    (state_q == ST_CALC) && corr_neg |=> dac_update.code == '0)
    else $error("underflow not clamped");
  sat_high_a: assert property (
    (state_q == ST_CALC) && corr_over |=> dac_update.code == DATA_FIELD_W'({RES{1'b1}}))
    else $error("overflow not clamped");
  awake_frame_a: assert property (
    !stable_q[0] |=> iface_awake)
    else $error("interface asleep during frame");
endmodule : dac_serial_word_decoder

// ---- bench/link_host_model.sv ----
/*
  Host side of the serial link: frames words MSB first and collects sdo.
  Assumes the caller leaves at least one frame gap between calls.
*/
`timescale 1ns/1ps
module link_host_model (
  // Link pins
  output logic link_sclk,
  output logic sync_n,
  output logic din,
  input wire logic sdo
);
  // ----------------------------------------
  // Frame driver
  // ----------------------------------------
  initial begin
    link_sclk = 1'b0;
    sync_n = 1'b1;
    din = 1'b0;
  end

  // Clock stands low outside frames; 160 ns period inside
  task automatic frame(input logic [47:0] w, input int n, output logic [23:0] rd);
    sync_n = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      din = w[i];
      #80 link_sclk = 1'b1;
      #80 link_sclk = 1'b0;
      rd = {rd[22:0], sdo};
    end
    #80 sync_n = 1'b1;
    // Released line shows no stale bit
    din = ~din;
    #200;
  endtask : frame
endmodule : link_host_model

// ---- bench/dac_serial_word_decoder_tb_top.sv ----
/*
  Self-checking bench for the serial word decoder (14-bit, 16 channels).
  Assumes the host model owns the link pins; mode pins move after mclk.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin n_fail++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module dac_serial_word_decoder_tb_top import dac_word_pkg::*; ;
  logic mclk, nrst, link_sclk, sync_n, din, sdo, iface_sel, chain_en, toggle_en;
  logic iface_awake, bad_frame, sfr_wr, dac_valid;
  frame_t sfr_word;
  dac_update_t dac_update, last_upd;
  logic [23:0] rd, rw_word;
  int n_fail, cmp_count, n_valid, n_sfr, n_bad, n_awake;

  // ----------------------------------------
  // Clock, instances, pulse monitor
  // ----------------------------------------
  initial mclk = 1'b0;
  always #5 mclk = ~mclk;

  dac_serial_word_decoder #(.RES(14), .CHANNELS(16)) dut_u (
    .mclk(mclk), .nrst(nrst), .link_sclk(link_sclk), .sync_n(sync_n), .din(din),
    .sdo(sdo), .iface_sel(iface_sel), .chain_enable_pin(chain_en),
    .toggle_en(toggle_en), .iface_awake(iface_awake), .bad_frame(bad_frame),
    .sfr_wr(sfr_wr), .sfr_word(sfr_word), .dac_valid(dac_valid),
    .dac_update(dac_update));

  link_host_model host_u (.link_sclk(link_sclk), .sync_n(sync_n), .din(din), .sdo(sdo));

  // Pulses last one cycle, so count them rather than poll; the
  // falling edge keeps the monitor clear of the launching edge
  always @(negedge mclk) begin
    if (dac_valid === 1'b1) begin
      n_valid++;
      last_upd = dac_update;
    end
    if (sfr_wr === 1'b1) n_sfr++;
    if (bad_frame === 1'b1) n_bad++;
    if (iface_awake === 1'b1) n_awake++;
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [47:0] mk(input logic bank, rw, input logic [3:0] ch,
                                     input logic [1:0] sel, input logic [13:0] d);
    return {24'h000000, bank, rw, 2'b00, ch, sel, d};
  endfunction : mk

  function automatic logic [13:0] corr(input int x, m, c);
    int v;
    v = ((m + 2) * x) / 16384 + c - 8192;
    if (v < 0) v = 0;
    if (v > 16383) v = 16383;
    return 14'(v);
  endfunction : corr

  task automatic xfer(input logic [47:0] w, input int n);
    n_valid = 0;
    n_sfr = 0;
    n_bad = 0;
    n_awake = 0;
    host_u.frame(w, n, rd);
    repeat (12) @(posedge mclk);
    #1;
  endtask : xfer

  task automatic tally_and_finish;
    if (n_fail == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : tally_and_finish

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    nrst = 1'b0;
    iface_sel = 1'b1;
    chain_en = 1'b0;
    toggle_en = 1'b0;
    repeat (10) @(posedge mclk);
    #1;
    `CHK({dac_valid, sfr_wr, bad_frame, dac_update}, 22'h0)
    nrst = 1'b1;
    repeat (4) @(posedge mclk);
    xfer(mk(0, 0, 4'h5, SEL_CODE, 14'h1234), 24);
    `CHK(last_upd, {4'h5, 1'b0, 14'h1234})
    `CHK(n_awake != 0, 1'b1)
    `CHK(iface_awake, 1'b0)
    xfer(mk(0, 0, 4'h5, SEL_OFFSET, 14'h3fff), 24);
    `CHK(last_upd.code, corr(16'h1234, 16'h3ffe, 16'h3fff))
    xfer(mk(0, 0, 4'h5, SEL_GAIN, 14'h1fff), 24);
    `CHK(last_upd.code, corr(16'h1234, 16'h1ffe, 16'h3fff))
    // Readback of gain, collected by an all-zero special function write frame
    rw_word = 24'(mk(0, 1, 4'h5, SEL_GAIN, 14'h2aaa));
    xfer(rw_word, 24);
    `CHK(n_valid, 0)
    xfer(48'h0, 24);
    `CHK(rd, {rw_word[23:14], 14'h1ffe})
    xfer(mk(0, 0, 4'h5, SEL_GAIN, 14'h3ffe), 24);
    xfer(mk(0, 0, 4'h5, SEL_CODE, 14'h3fff), 24);
    `CHK(last_upd.code, 14'h3fff)
    xfer(mk(0, 0, 4'h5, SEL_OFFSET, 14'h0000), 24);
    `CHK(last_upd.code, 14'h1fff)
    xfer(mk(0, 0, 4'h5, SEL_CODE, 14'h0001), 24);
    `CHK(last_upd.code, 14'h0000)
    xfer(mk(0, 0, 4'ha, SEL_CODE, 14'h0abc), 24);
    `CHK(last_upd, {4'ha, 1'b0, 14'h0abc})
    xfer(mk(0, 0, 4'h3, SEL_SFR, 14'h0155), 24);
    `CHK({n_sfr, n_valid}, {32'd1, 32'd0})
    `CHK(sfr_word, 24'(mk(0, 0, 4'h3, SEL_SFR, 14'h0155)))
    xfer(mk(0, 0, 4'h6, SEL_CODE, 14'h0fff), 10);
    `CHK({n_bad, n_valid}, {32'd1, 32'd0})
    @(posedge mclk);
    #1;
    toggle_en = 1'b1;
    xfer(mk(1, 0, 4'h2, SEL_CODE, 14'h0100), 24);
    `CHK(last_upd, {4'h2, 1'b1, 14'h0100})
    @(posedge mclk);
    #1;
    iface_sel = 1'b0;
    xfer(mk(0, 0, 4'h2, SEL_CODE, 14'h0200), 24);
    `CHK(n_valid, 0)
    @(posedge mclk);
    #1;
    iface_sel = 1'b1;
    chain_en = 1'b1;
    xfer({24'(mk(0, 0, 4'h3, SEL_CODE, 14'h0000)), 24'(mk(0, 0, 4'h1, SEL_CODE, 14'h0777))}, 48);
    `CHK({n_valid, last_upd}, {32'd1, 4'h1, 1'b0, 14'h0777})
    `CHK(rd, 24'(mk(0, 0, 4'h3, SEL_CODE, 14'h0000)))
    tally_and_finish();
  end

  // Run needs about 65 us; allow generous margin
  initial begin
    #400000;
    n_fail++;
    tally_and_finish();
  end
endmodule : dac_serial_word_decoder_tb_top
